// ==== design/flash_host_cfg.svh ====
/*
 Constants of the flash program/erase host: opcodes, register map, field
 positions and timing. Assumes a 10 MHz pclk and a flash in SPI mode 0.
*/
// Operation
// R1: Quad program 32H, write enable first
// R2: Device keeps last 256 bytes only
// R3: Short program leaves other bytes unchanged
// R4: Chip select rises on data byte boundary
// R5: Device self-times program, flags busy
// R6: Device refuses program in protected page
// R7: Sector erase 20H, three address bytes
// R8: Sector erase ends after last address byte
// R9: Device self-times sector erase, flags busy
// R10: Device refuses erase of protected sector
// R11: Block erase 52H, three address bytes
// R12: 32KB erase ends after address byte
// R13: Device refuses protected 32KB block
// R14: Block erase D8H, three address bytes
// R15: 64KB erase ends after address byte
// R16: Device refuses protected 64KB block
// R17: Chip erase 60H or C7H, no address
// R18: Chip erase ends after opcode byte
// R19: Device self-times chip erase, flags busy
// R20: Chip erase only unprotected protect setting
// R21: Device ignores chip erase if protected
// R22: Chip select low through whole sequence
// R23: Device wraps program data within page
// R24: Device ignores commands without write latch
// R25: No new command while cycle runs
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH
// Flash opcodes
`define OPC_PROG 8'h32
`define OPC_SECT 8'h20
`define OPC_BLK32 8'h52
`define OPC_BLK64 8'hd8
`define OPC_CHIP60 8'h60
`define OPC_CHIPC7 8'hc7
`define OPC_WRITE_ENABLE_CMD 8'h06
`define OPC_RDSR 8'h05
`define WIP_BIT 0
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_LEN 8'h08
`define REG_DATA 8'h0c
`define REG_STAT 8'h10
// Fields
`define CTRL_START 8
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_ERR 2
`define STAT_FS_LO 8
// Timing
`define PCLK_MHZ 10
`define SCLK_HALF 4'd4
`define CS_GAP_NS 100
`define CS_GAP_CYC ((`CS_GAP_NS * `PCLK_MHZ + 999) / 1000)
`endif

// ==== design/flash_host_pkg.sv ====
/*
 Types of the flash program/erase host.
 Assumes flash_host_cfg.svh is on the include path.
*/
`include "flash_host_cfg.svh"
package flash_host_pkg;
   typedef enum logic [2:0] {OP_PROG, OP_SECT, OP_BLK32, OP_BLK64, OP_CHIP60,
      OP_CHIPC7, OP_BAD6, OP_BAD7} flash_op_e;
   typedef enum logic [3:0] {ST_IDLE, ST_WRITE_ENABLE_CMD, ST_GAP, ST_OP, ST_ADDR, ST_DWAIT,
      ST_DATA, ST_POLL_OP, ST_POLL_RD} phase_e;
   typedef struct packed {
      phase_e ph;
      phase_e after;
      flash_op_e op;
      logic [23:0] addr;
      logic [8:0] len;
      logic [8:0] left;
      logic [1:0] abyte;
      logic [7:0] sh;
      logic [7:0] rx;
      logic [3:0] steps;
      logic xfer;
      logic quad;
      logic rd;
      logic cs_n;
      logic sclk;
      logic [7:0] gap;
      logic done;
      logic err;
      logic [7:0] fstat;
      logic s1;
      logic s2;
      logic [31:0] prd;
   } host_s;
   typedef struct packed {
      logic [3:0] cnt;
      logic tick;
   } div_s;
   function automatic logic [7:0] op_code(flash_op_e op);
      case (op)
         OP_PROG: op_code = `OPC_PROG;
         OP_SECT: op_code = `OPC_SECT;
         OP_BLK32: op_code = `OPC_BLK32;
         OP_BLK64: op_code = `OPC_BLK64;
         OP_CHIP60: op_code = `OPC_CHIP60;
         default: op_code = `OPC_CHIPC7;
      endcase
   endfunction
endpackage

// ==== design/sclk_tick.sv ====
/*
 Divider that gives a one-cycle enable every SCLK_HALF pclk cycles while
 run is high. Assumes run comes from logic on pclk.
*/
`include "flash_host_cfg.svh"
module sclk_tick (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic run,
   output logic tick
);
   import flash_host_pkg::*;
   div_s q, n;
   always_comb begin
      n = q;
      n.tick = 1'b0;
      // Restart when idle so the first edge gets a full half period
      if (!run) begin
         n.cnt = 4'h0;
      end else if (q.cnt == `SCLK_HALF - 4'd1) begin
         n.cnt = 4'h0;
         n.tick = 1'b1;
      end else begin
         n.cnt = q.cnt + 4'd1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
   assign tick = q.tick;
endmodule

// ==== design/flash_cmd_host.sv ====
/*
 APB-controlled host that issues write enable, then quad page program, sector,
 block or chip erase to a serial NOR flash, and polls its busy flag.
 Assumes SPI mode 0, pull-ups on the io lines, and an APB master on pclk.
*/
`include "flash_host_cfg.svh"
module flash_cmd_host (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash pins
   output logic cs_n,
   output logic sclk,
   output logic [3:0] io_out,
   output logic [3:0] io_oe_n,
   input wire logic [3:0] io_in
);
   import flash_host_pkg::*;
   host_s q, n;
   logic tick;
   logic [7:0] off;
   logic acc;
   logic data_wr;
   logic start_wr;
   logic busy;
   logic chip_op;

   sclk_tick u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .run(q.xfer),
      .tick(tick)
   );

   function automatic host_s load_byte(host_s s, logic [7:0] b, logic qd);
      host_s r;
      r = s;
      r.sh = b;
      r.steps = qd ? 4'd2 : 4'd8;
      r.quad = qd;
      r.xfer = 1'b1;
      r.cs_n = 1'b0;
      return r;
   endfunction

   assign off = paddr[7:0];
   assign busy = (q.ph != ST_IDLE);
   assign chip_op = (q.op == OP_CHIP60) || (q.op == OP_CHIPC7);
   assign data_wr = psel && penable && pwrite && (off == `REG_DATA);
   // Back-pressure: a data byte waits while the previous one shifts
   assign pready = !(data_wr && q.ph == ST_DATA);
   assign acc = psel && penable && pready;
   assign start_wr = acc && pwrite && (off == `REG_CTRL) && pwdata[`CTRL_START];

   always_comb begin
      n = q;
      n.s1 = io_in[1];
      n.s2 = q.s1;
      pslverr = 1'b0;
      if (psel && penable) begin
         case (off)
            `REG_CTRL, `REG_ADDR, `REG_LEN, `REG_STAT: pslverr = 1'b0;
            `REG_DATA: pslverr = !pwrite || !(q.ph == ST_DWAIT || q.ph == ST_DATA);
            default: pslverr = 1'b1;
         endcase
      end
      // Read data captured in the setup cycle
      if (psel && !penable) begin
         case (off)
            `REG_CTRL: n.prd = {29'h0, q.op};
            `REG_ADDR: n.prd = {8'h0, q.addr};
            `REG_LEN: n.prd = {23'h0, q.len};
            `REG_STAT: n.prd = {16'h0, q.fstat, 5'h0, q.err, q.done, busy};
            default: n.prd = 32'h0;
         endcase
      end
      if (acc && pwrite) begin
         case (off)
            `REG_ADDR: if (!busy) n.addr = pwdata[23:0];
            `REG_LEN: if (!busy) n.len = pwdata[8:0];
            `REG_STAT: begin
               if (pwdata[`STAT_DONE]) n.done = 1'b0;
               if (pwdata[`STAT_ERR]) n.err = 1'b0;
            end
            `REG_DATA: begin
               if (q.ph == ST_DWAIT) begin
                  n = load_byte(n, pwdata[7:0], 1'b1);
                  n.left = q.left - 9'd1;
                  n.ph = ST_DATA;
               end
            end
            default: ;
         endcase
      end
      if (start_wr) begin
         if (busy) begin
            n.err = 1'b1; // [R25]
         end else if (pwdata[2:0] > 3'(OP_CHIPC7) ||
               (flash_op_e'(pwdata[2:0]) == OP_PROG && q.len == 9'h0)) begin
            n.err = 1'b1;
         end else begin
            n.op = flash_op_e'(pwdata[2:0]);
            n.left = q.len;
            n.rd = 1'b0;
            n = load_byte(n, `OPC_WRITE_ENABLE_CMD, 1'b0); // [R1] [R7] [R11] [R14] [R17]
            n.ph = ST_WRITE_ENABLE_CMD;
         end
      end
      // Bit engine: rise to let the flash latch, fall to present the next bit
      if (q.xfer && tick) begin
         if (!q.sclk) begin
            n.sclk = 1'b1;
            n.rx = {q.rx[6:0], q.s2};
         end else begin
            n.sclk = 1'b0;
            n.sh = q.quad ? {q.sh[3:0], 4'h0} : {q.sh[6:0], 1'b0};
            n.steps = q.steps - 4'd1;
            if (q.steps == 4'd1) n.xfer = 1'b0;
         end
      end
      if (!q.xfer) begin
         case (q.ph)
            ST_IDLE: ;
            ST_WRITE_ENABLE_CMD: begin
               n.cs_n = 1'b1;
               n.gap = 8'(`CS_GAP_CYC);
               n.after = ST_OP;
               n.ph = ST_GAP;
            end
            ST_GAP: begin
               if (q.gap != 8'h0) begin
                  n.gap = q.gap - 8'h1;
               end else if (q.after == ST_OP) begin
                  n = load_byte(n, op_code(q.op), 1'b0);
                  n.ph = ST_OP;
               end else begin
                  n = load_byte(n, `OPC_RDSR, 1'b0);
                  n.ph = ST_POLL_OP;
               end
            end
            ST_OP: begin
               if (chip_op) begin
                  n.cs_n = 1'b1; // [R18]
                  n.gap = 8'(`CS_GAP_CYC);
                  n.after = ST_POLL_OP;
                  n.ph = ST_GAP;
               end else begin
                  n = load_byte(n, q.addr[23:16], 1'b0);
                  n.addr = {q.addr[15:0], q.addr[23:16]};
                  n.abyte = 2'd2;
                  n.ph = ST_ADDR;
               end
            end
            ST_ADDR: begin
               if (q.abyte != 2'd0) begin
                  n = load_byte(n, q.addr[23:16], 1'b0);
                  n.addr = {q.addr[15:0], q.addr[23:16]};
                  n.abyte = q.abyte - 2'd1;
               end else if (q.op == OP_PROG) begin
                  n.ph = ST_DWAIT; // [R22]
               end else begin
                  n.cs_n = 1'b1; // [R8] [R12] [R15]
                  n.gap = 8'(`CS_GAP_CYC);
                  n.after = ST_POLL_OP;
                  n.ph = ST_GAP;
               end
            end
            ST_DWAIT: ;
            ST_DATA: begin
               if (q.left == 9'h0) begin
                  n.cs_n = 1'b1; // [R4]
                  n.gap = 8'(`CS_GAP_CYC);
                  n.after = ST_POLL_OP;
                  n.ph = ST_GAP;
               end else begin
                  n.ph = ST_DWAIT;
               end
            end
            ST_POLL_OP: begin
               n = load_byte(n, 8'h00, 1'b0);
               n.rd = 1'b1;
               n.ph = ST_POLL_RD;
            end
            ST_POLL_RD: begin
               n.fstat = q.rx;
               // Status repeats while chip select stays low
               if (q.rx[`WIP_BIT]) begin
                  n = load_byte(n, 8'h00, 1'b0);
               end else begin
                  n.cs_n = 1'b1;
                  n.rd = 1'b0;
                  n.done = 1'b1;
                  n.ph = ST_IDLE;
               end
            end
            default: n.ph = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.cs_n <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign prdata = q.prd;
   assign cs_n = q.cs_n;
   assign sclk = q.sclk;
   // io2/io3 released outside quad data so pull-ups hold them high
   assign io_out = q.quad ? q.sh[7:4] : {3'h0, q.sh[7]};
   assign io_oe_n = (q.cs_n || q.rd) ? 4'hf : (q.quad ? 4'h0 : 4'he);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_start_ok;
      start_wr && !busy && pwdata[2:0] <= 3'(OP_CHIPC7) &&
         !(pwdata[2:0] == 3'(OP_PROG) && q.len == 9'h0);
   endsequence
   sequence s_write_enable_cmd_sent;
      q.ph == ST_WRITE_ENABLE_CMD && q.sh == `OPC_WRITE_ENABLE_CMD && !q.cs_n;
   endsequence
   sequence s_op_end;
      q.ph == ST_OP && !q.xfer;
   endsequence

   chk_write_enable_cmd_first: assert property (s_start_ok |=> s_write_enable_cmd_sent) // [R1]
      else $error("write enable not sent first");
   // A refused start may arrive while write enable is still shifting
   chk_busy_refuse: assert property (start_wr && busy |=> q.err &&
         !(q.ph == ST_WRITE_ENABLE_CMD && $past(q.ph) != ST_WRITE_ENABLE_CMD)) // [R25]
      else $error("start accepted while busy");
   chk_cs_byte_edge: assert property ($rose(q.cs_n) |-> !$past(q.xfer) && !q.sclk) // [R4] [R8]
      else $error("chip select rose inside a byte");
   chk_cs_held_low: assert property (q.ph inside {ST_OP, ST_ADDR, ST_DWAIT, ST_DATA}
         |-> !q.cs_n) // [R22]
      else $error("chip select high mid sequence");
   chk_opcode_sent: assert property ($rose(q.ph == ST_OP) |-> q.sh == op_code(q.op) &&
         q.steps == 4'd8) // [R7] [R11] [R14] [R17]
      else $error("wrong opcode loaded");
   chk_chip_no_addr: assert property (s_op_end and chip_op |=> q.cs_n ##0
         q.ph == ST_GAP) // [R18]
      else $error("chip erase not ended after opcode");
   chk_erase_addr_end: assert property (q.ph == ST_ADDR && !q.xfer && q.abyte == 2'd0 &&
         q.op != OP_PROG |=> q.cs_n && q.after == ST_POLL_OP) // [R12] [R15]
      else $error("erase not ended after third address byte");
   chk_quad_lines: assert property (q.ph == ST_DATA && q.xfer |-> io_oe_n == 4'h0 &&
         q.steps <= 4'd2) // [R1]
      else $error("data byte not on four lines");
   chk_byte_length: assert property ($rose(q.xfer) && !q.quad |-> q.xfer [*8]) // [R4]
      else $error("single-line byte too short");
endmodule

// ==== verification/flash_dev_model.sv ====
/*
 Behavioural serial flash: write enable, quad program of one page, erases,
 status read on io1. Assumes pull-ups on the io lines outside it.
*/
module flash_dev_model #(
   parameter int BUSY = 40
) (
   // Timing and protection
   input wire logic pclk,
   input wire logic prot,
   // Pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] io,
   output logic so,
   output logic so_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] opc, sh, last_op, k, stat;
   logic [7:0] mem [256];
   logic [7:0] pbuf [256];
   logic [255:0] pmask;
   logic [23:0] adr, last_adr;
   logic write_enable_latch = 1'b0;
   int cnt = 0;
   int busy = 0;
   int n_exec = 0;
   assign stat = {6'h0, write_enable_latch, busy != 0};
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      so = 1'b0;
      so_oe = 1'b0;
   end
   always @(posedge pclk) if (busy > 0) busy--;
   always @(negedge cs_n) begin
      cnt = 0;
      pmask = '0;
   end
   always @(posedge sclk) begin
      if (!cs_n) begin
         if (cnt < 8) opc = {opc[6:0], io[0]};
         else if (cnt < 32) adr = {adr[22:0], io[0]};
         else if (opc == 8'h32) begin
            sh = {sh[3:0], io};
            // Wrap in page keeps the last 256 bytes
            k = adr[7:0] + 8'((cnt - 33) / 2);
            if (cnt[0]) pbuf[k] = sh;
            if (cnt[0]) pmask[k] = 1'b1;
         end
         cnt++;
      end
   end
   always @(negedge sclk) begin
      if (!cs_n && opc == 8'h05 && cnt >= 8) begin
         so_oe = 1'b1;
         so = stat[7 - (cnt - 8) % 8];
      end
   end
   function automatic logic ends_ok();
      case (opc)
         8'h20, 8'h52, 8'hd8: return cnt == 32;
         8'h60, 8'hc7: return cnt == 8;
         8'h32: return cnt > 32 && !cnt[0];
         default: return 1'b0;
      endcase
   endfunction
   always @(posedge cs_n) begin
      so_oe = 1'b0;
      if (busy == 0) begin
         if (opc == 8'h06 && cnt == 8) write_enable_latch = 1'b1;
         // Prot stands for any covered target
         else if (write_enable_latch && !prot && ends_ok()) begin
            n_exec++;
            last_op = opc;
            last_adr = adr;
            write_enable_latch = 1'b0;
            busy = BUSY;
            foreach (pmask[i]) if (pmask[i] && opc == 8'h32) mem[i] = pbuf[i];
         end
      end
   end
endmodule

// ==== verification/flash_program_erase_cmds_tb.sv ====
/*
 Testbench of the flash program/erase host: APB stimulus, flash model on pins.
 Assumes the design and flash_dev_model are compiled before it.
*/
`include "flash_host_cfg.svh"
module flash_program_erase_cmds_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cs_n, sclk, so, so_oe, prot;
   logic er;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [3:0] io_out, io_oe_n, io_in;
   int miscompares, n_checks, cyc, base;
   typedef struct {logic [2:0] op; logic [23:0] a; logic [7:0] opc;} row_s;
   row_s rows [5] = '{'{3'd1, 24'h12345a, 8'h20}, '{3'd2, 24'h0a8001, 8'h52},
      '{3'd3, 24'hff7ffe, 8'hd8}, '{3'd4, 24'h0, 8'h60}, '{3'd5, 24'h0, 8'hc7}};
   // Pulled-up lines; io1 also carries the status bits
   assign io_in = {io_oe_n[3:2] | io_out[3:2], so_oe ? so : io_oe_n[1] | io_out[1],
      io_oe_n[0] | io_out[0]};
   flash_cmd_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .io_out(io_out), .io_oe_n(io_oe_n),
      .io_in(io_in));
   flash_dev_model m (.pclk(pclk), .prot(prot), .cs_n(cs_n), .sclk(sclk), .io(io_in),
      .so(so), .so_oe(so_oe));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic test_done();
      $display("Checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         miscompares++;
         test_done();
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Look between edges so the answer is settled when taken
      @(negedge pclk);
      while (pready !== 1'b1) @(negedge pclk);
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic start(input logic [2:0] op, input logic [23:0] a);
      base = m.n_exec;
      apb(1'b1, `REG_ADDR, {8'h0, a});
      apb(1'b1, `REG_CTRL, {23'h0, 1'b1, 5'h0, op});
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 600; i++) begin
         apb(1'b0, `REG_STAT, 32'h0);
         if (rd[0] === 1'b0) break;
      end
   endtask
   initial begin
      {psel, penable, pwrite, prot} = 4'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      check("reset cs_n", cs_n, 1'b1);
      check("reset io_oe_n", io_oe_n, 4'hf);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         start(rows[i].op, rows[i].a);
         wait_idle();
         check("opcode", m.last_op, rows[i].opc);
         check("executed", m.n_exec, base + 1);
         if (rows[i].op < 4) check("address", m.last_adr, rows[i].a);
         check("status", rd[15:0], 16'h0002);
         apb(1'b1, `REG_STAT, 32'h2);
      end
      // Three bytes from the page end wrap to its start
      apb(1'b1, `REG_LEN, 32'h3);
      start(3'd0, 24'h0000fe);
      repeat (2) @(negedge cs_n);
      repeat (32) @(posedge sclk);
      @(negedge sclk);
      apb(1'b1, `REG_DATA, 32'ha1);
      apb(1'b1, `REG_DATA, 32'hb2);
      apb(1'b1, `REG_DATA, 32'hc3);
      wait_idle();
      check("wrap", {m.mem[8'hfe], m.mem[8'hff], m.mem[8'h00]}, 24'ha1b2c3);
      check("untouched", m.mem[8'h01], 8'hff);
      check("program", m.n_exec, base + 1);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped", er, 1'b1);
      apb(1'b0, `REG_DATA, 32'h0);
      check("data read", er, 1'b1);
      apb(1'b1, `REG_CTRL, 32'h106);
      apb(1'b0, `REG_STAT, 32'h0);
      check("bad op", rd[2], 1'b1);
      start(3'd1, 24'h001000);
      apb(1'b1, `REG_CTRL, 32'h101);
      wait_idle();
      check("busy start", rd[2:0], 3'b110);
      check("single run", m.n_exec, base + 1);
      apb(1'b1, `REG_STAT, 32'h6);
      prot <= 1'b1;
      start(3'd1, 24'h002000);
      wait_idle();
      start(3'd4, 24'h0);
      wait_idle();
      check("protected", m.n_exec, base);
      prot <= 1'b0;
      // Reset in mid-address cancels the erase
      start(3'd2, 24'h008000);
      repeat (2) @(negedge cs_n);
      repeat (12) @(posedge sclk);
      presetn <= 1'b0;
      @(posedge pclk);
      check("mid reset cs_n", cs_n, 1'b1);
      check("mid reset io", io_oe_n, 4'hf);
      presetn <= 1'b1;
      check("cancelled", m.n_exec, base);
      test_done();
   end
endmodule
